// ==== mst_stream_video_attribute_regs.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Framing waits programmed initial cycles at each new line start.
// - Hold 16-bit horizontal total in clocks.
// - Hold 16-bit vertical total in lines per frame.
// - Polarity register: bit 1 vertical sync, bit 0 horizontal sync.
// - Hold 15-bit horizontal sync width in clocks.
// - Hold 15-bit vertical sync width in lines.
// - Hold 16-bit active pixels per line.
// - Hold 16-bit active lines per frame.
// - Hold 16-bit clocks from hsync leading edge to active data.
// - Hold 16-bit lines from vsync leading edge to first active line.
// - Attribute byte A: sync clock, format, range, colorimetry, bit depth.
// - Attribute byte B: even interlace total, stereo bits, 6:3 reserved.
// - Async mode: computed M is sent but never copied to register.
// - Async mode: derived N never written back to register.
// - Seven-bit transfer-unit size resets to 64.
// - Size kept 32..64 by software; bit 0 writes ignored, always even.
// - Pixel width codes 1, 2, 4; quad required in multi-stream.
module mst_stream_video_attribute_regs (
   input  wire logic                                 core_clk,   // Core clock
   input  wire logic                                 rst,        // Async reset
   input  wire logic [stream_attr_pkg::ADDR_W-1:0]   address,    // Byte address
   input  wire logic                                 read,       // Read strobe
   input  wire logic                                 write,      // Write strobe
   input  wire logic [stream_attr_pkg::DATA_W-1:0]   writedata,  // Write data
   input  wire logic [3:0]                           byteenable, // Byte lanes
   output      logic [stream_attr_pkg::DATA_W-1:0]   readdata,   // Read data
   output      logic                                 waitrequest,// Stall
   output      logic [1:0]                           response,   // 0 ok 2 err
   input  wire logic                                 line_start, // New line
   output      logic                                 line_data_enable, // Emit
   output      stream_attr_pkg::stream_cfg_s         stream_cfg  // Settings
);

   typedef struct packed {
      stream_attr_pkg::stream_cfg_s      cfg;
      logic [stream_attr_pkg::WAIT_W-1:0] line_wait;
      logic [stream_attr_pkg::WAIT_W-1:0] wait_count;
      stream_attr_pkg::line_state_e      line_state;
      logic                              ack;
      logic [stream_attr_pkg::DATA_W-1:0] rdata;
      logic [1:0]                        resp;
   } state_s;

   state_s state;
   state_s next_state;

   // Merge write data into a field under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic hit(input logic [11:0] a);
      logic [11:0] w;
      w = a;
      unique case (w)
         stream_attr_pkg::OFS_S3_TU_MIN_BYTES,
         stream_attr_pkg::OFS_S3_TU_FRACTION_BYTES,
         stream_attr_pkg::OFS_S3_LINE_START_WAIT,
         stream_attr_pkg::OFS_S4_HORIZONTAL_TOTAL,
         stream_attr_pkg::OFS_S4_VERTICAL_TOTAL,
         stream_attr_pkg::OFS_S4_SYNC_POLARITY,
         stream_attr_pkg::OFS_S4_HSYNC_WIDTH,
         stream_attr_pkg::OFS_S4_VSYNC_WIDTH,
         stream_attr_pkg::OFS_S4_ACTIVE_WIDTH,
         stream_attr_pkg::OFS_S4_ACTIVE_HEIGHT,
         stream_attr_pkg::OFS_S4_HORIZONTAL_START,
         stream_attr_pkg::OFS_S4_VERTICAL_START,
         stream_attr_pkg::OFS_S4_FORMAT_ATTR_A,
         stream_attr_pkg::OFS_S4_FORMAT_ATTR_B,
         stream_attr_pkg::OFS_S4_CLOCK_RATIO_NUM,
         stream_attr_pkg::OFS_S4_TRANSFER_UNIT_LEN,
         stream_attr_pkg::OFS_S4_CLOCK_RATIO_DEN,
         stream_attr_pkg::OFS_S4_PIXEL_PORT_WIDTH: return 1'b1;
         default:                                  return 1'b0;
      endcase
   endfunction

   // Current register image as seen on the bus
   function automatic logic [31:0] image(input state_s s,
                                         input logic [11:0] a);
      logic [31:0] v;
      v = 32'h0;
      unique case (a)
         stream_attr_pkg::OFS_S3_TU_MIN_BYTES:
            v[7:0] = s.cfg.s3_tu_min_bytes;
         stream_attr_pkg::OFS_S3_TU_FRACTION_BYTES:
            v[9:0] = s.cfg.s3_tu_fraction_bytes;
         stream_attr_pkg::OFS_S3_LINE_START_WAIT:
            v[7:0] = s.line_wait;
         stream_attr_pkg::OFS_S4_HORIZONTAL_TOTAL:
            v[15:0] = s.cfg.horizontal_total;
         stream_attr_pkg::OFS_S4_VERTICAL_TOTAL:
            v[15:0] = s.cfg.vertical_total;
         stream_attr_pkg::OFS_S4_SYNC_POLARITY: begin
            v[stream_attr_pkg::POL_VSYNC_BIT] = s.cfg.vsync_polarity;
            v[stream_attr_pkg::POL_HSYNC_BIT] = s.cfg.hsync_polarity;
         end
         stream_attr_pkg::OFS_S4_HSYNC_WIDTH:
            v[14:0] = s.cfg.hsync_width;
         stream_attr_pkg::OFS_S4_VSYNC_WIDTH:
            v[14:0] = s.cfg.vsync_width;
         stream_attr_pkg::OFS_S4_ACTIVE_WIDTH:
            v[15:0] = s.cfg.active_width;
         stream_attr_pkg::OFS_S4_ACTIVE_HEIGHT:
            v[15:0] = s.cfg.active_height;
         stream_attr_pkg::OFS_S4_HORIZONTAL_START:
            v[15:0] = s.cfg.horizontal_start;
         stream_attr_pkg::OFS_S4_VERTICAL_START:
            v[15:0] = s.cfg.vertical_start;
         stream_attr_pkg::OFS_S4_FORMAT_ATTR_A:
            v[7:0] = {s.cfg.bit_depth, s.cfg.ycbcr_colorimetry,
                      s.cfg.dynamic_range, s.cfg.component_format,
                      s.cfg.sync_clock};
         stream_attr_pkg::OFS_S4_FORMAT_ATTR_B:
            v[2:0] = {s.cfg.stereo_attr, s.cfg.interlace_even};
         stream_attr_pkg::OFS_S4_CLOCK_RATIO_NUM:
            v[23:0] = s.cfg.clock_ratio_numerator;
         stream_attr_pkg::OFS_S4_TRANSFER_UNIT_LEN:
            v[6:0] = s.cfg.transfer_unit_length;
         stream_attr_pkg::OFS_S4_CLOCK_RATIO_DEN:
            v[23:0] = s.cfg.clock_ratio_denominator;
         stream_attr_pkg::OFS_S4_PIXEL_PORT_WIDTH:
            v[2:0] = s.cfg.pixel_port_width;
         default:
            v = 32'h0;
      endcase
      return v;
   endfunction

   always_comb begin
      logic [31:0] m;
      logic        req;
      logic        ok;
      m  = 32'h0;
      req = (read | write) & ~state.ack;
      ok  = hit(address);
      next_state = state;
      next_state.ack = req;
      if (req) begin
         next_state.resp  = ok ? 2'h0 : 2'h2;
         next_state.rdata = (read && ok) ? image(state, address) : 32'h0;
      end
      if (req && write && ok) begin
         m = merge(image(state, address), writedata, byteenable);
         unique case (address)
            stream_attr_pkg::OFS_S3_TU_MIN_BYTES:
               next_state.cfg.s3_tu_min_bytes = m[7:0];
            stream_attr_pkg::OFS_S3_TU_FRACTION_BYTES:
               next_state.cfg.s3_tu_fraction_bytes = m[9:0];
            stream_attr_pkg::OFS_S3_LINE_START_WAIT:
               next_state.line_wait = m[7:0];
            stream_attr_pkg::OFS_S4_HORIZONTAL_TOTAL:
               next_state.cfg.horizontal_total = m[15:0];
            stream_attr_pkg::OFS_S4_VERTICAL_TOTAL:
               next_state.cfg.vertical_total = m[15:0];
            stream_attr_pkg::OFS_S4_SYNC_POLARITY: begin
               next_state.cfg.vsync_polarity =
                  m[stream_attr_pkg::POL_VSYNC_BIT];
               next_state.cfg.hsync_polarity =
                  m[stream_attr_pkg::POL_HSYNC_BIT];
            end
            stream_attr_pkg::OFS_S4_HSYNC_WIDTH:
               next_state.cfg.hsync_width = m[14:0];
            stream_attr_pkg::OFS_S4_VSYNC_WIDTH:
               next_state.cfg.vsync_width = m[14:0];
            stream_attr_pkg::OFS_S4_ACTIVE_WIDTH:
               next_state.cfg.active_width = m[15:0];
            stream_attr_pkg::OFS_S4_ACTIVE_HEIGHT:
               next_state.cfg.active_height = m[15:0];
            stream_attr_pkg::OFS_S4_HORIZONTAL_START:
               next_state.cfg.horizontal_start = m[15:0];
            stream_attr_pkg::OFS_S4_VERTICAL_START:
               next_state.cfg.vertical_start = m[15:0];
            stream_attr_pkg::OFS_S4_FORMAT_ATTR_A: begin
               next_state.cfg.sync_clock = m[0];
               next_state.cfg.component_format = m[2:1];
               next_state.cfg.dynamic_range = m[3];
               next_state.cfg.ycbcr_colorimetry = m[4];
               next_state.cfg.bit_depth = m[7:5];
            end
            stream_attr_pkg::OFS_S4_FORMAT_ATTR_B: begin
               // Bits 6:3 reserved, read as zero
               next_state.cfg.interlace_even = m[0];
               next_state.cfg.stereo_attr = m[2:1];
            end
            // Only software writes reach these; computed values never do
            stream_attr_pkg::OFS_S4_CLOCK_RATIO_NUM:
               next_state.cfg.clock_ratio_numerator = m[23:0];
            stream_attr_pkg::OFS_S4_TRANSFER_UNIT_LEN:
               next_state.cfg.transfer_unit_length =
                  {m[6:1], state.cfg.transfer_unit_length[0]};
            stream_attr_pkg::OFS_S4_CLOCK_RATIO_DEN:
               next_state.cfg.clock_ratio_denominator = m[23:0];
            stream_attr_pkg::OFS_S4_PIXEL_PORT_WIDTH:
               next_state.cfg.pixel_port_width = m[2:0];
            default: ;
         endcase
      end

      // Line start wait sequencer
      unique case (state.line_state)
         stream_attr_pkg::LINE_IDLE: begin
            if (line_start) begin
               next_state.wait_count = state.line_wait;
               next_state.line_state = (state.line_wait == 8'h00) ?
                  stream_attr_pkg::LINE_SEND : stream_attr_pkg::LINE_WAIT;
            end
         end
         stream_attr_pkg::LINE_WAIT: begin
            // Restart with a zero wait must not wrap the counter
            if (line_start) begin
               next_state.wait_count = state.line_wait;
               next_state.line_state = (state.line_wait == 8'h00) ?
                  stream_attr_pkg::LINE_SEND : stream_attr_pkg::LINE_WAIT;
            end else if (state.wait_count == 8'h01) begin
               next_state.wait_count = 8'h00;
               next_state.line_state = stream_attr_pkg::LINE_SEND;
            end else begin
               next_state.wait_count = state.wait_count - 8'h01;
            end
         end
         stream_attr_pkg::LINE_SEND: begin
            if (line_start) begin
               next_state.wait_count = state.line_wait;
               next_state.line_state = (state.line_wait == 8'h00) ?
                  stream_attr_pkg::LINE_SEND : stream_attr_pkg::LINE_WAIT;
            end
         end
         default: next_state.line_state = stream_attr_pkg::LINE_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= '0;
         state.cfg.transfer_unit_length <= stream_attr_pkg::TU_LEN_RESET;
         state.line_wait <= stream_attr_pkg::LINE_WAIT_RESET;
         state.line_state <= stream_attr_pkg::LINE_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign waitrequest = (read | write) & ~state.ack;
   assign readdata = state.rdata;
   assign response = state.resp;
   assign stream_cfg = state.cfg;
   assign line_data_enable = (state.line_state == stream_attr_pkg::LINE_SEND);

endmodule

// ==== stream_attr_asserts.sv ====
`timescale 1ns/10ps
module stream_attr_asserts (
   input wire logic                         core_clk,         // Clock
   input wire logic                         rst,              // Reset
   input wire logic [11:0]                  address,          // Address
   input wire logic                         read,             // Read
   input wire logic                         write,            // Write
   input wire logic [31:0]                  writedata,        // Data
   input wire logic [3:0]                   byteenable,       // Lanes
   input wire logic                         waitrequest,      // Stall
   input wire logic                         line_start,       // New line
   input wire logic                         line_data_enable, // Emit
   input wire stream_attr_pkg::stream_cfg_s stream_cfg        // Settings
);
   logic [7:0] wait_q;
   logic [7:0] rem;
   logic       seen;

   // Shadow of the line wait count
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wait_q <= 8'h00;
         rem    <= 8'h00;
         seen   <= 1'b0;
      end else begin
         if (write && address == 12'h59c && byteenable[0])
            wait_q <= writedata[7:0];
         if (line_start) begin
            rem  <= wait_q;
            seen <= 1'b1;
         end else if (rem != 8'h00)
            rem <= rem - 8'h01;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_wait_one: assert property ((read || write) && waitrequest |=>
      !waitrequest) else $error("access not answered after one wait");
   chk_tu_even: assert property (stream_cfg.transfer_unit_length[0] == 1'b0)
      else $error("transfer unit size odd");
   chk_tu_write: assert property (write && waitrequest &&
      address == 12'h5d0 && byteenable[0] |=> stream_cfg.transfer_unit_length
      == {$past(writedata[6:1]), 1'b0}) else $error("unit size not loaded");
   chk_horizontal_total_load: assert property (write && waitrequest &&
      address == 12'h5a0 && byteenable[1:0] == 2'b11 |=>
      stream_cfg.horizontal_total == $past(writedata[15:0]))
      else $error("horizontal total not loaded");
   chk_sync_pol: assert property (write && waitrequest &&
      address == 12'h5a8 && byteenable[0] |=> {stream_cfg.vsync_polarity,
      stream_cfg.hsync_polarity} == $past(writedata[1:0]))
      else $error("polarity bits misplaced");
   chk_attr_a: assert property (write && waitrequest &&
      address == 12'h5c4 && byteenable[0] |=> {stream_cfg.bit_depth,
      stream_cfg.ycbcr_colorimetry, stream_cfg.dynamic_range,
      stream_cfg.component_format, stream_cfg.sync_clock}
      == $past(writedata[7:0])) else $error("attribute byte misplaced");
   chk_ratio_num: assert property (write && waitrequest &&
      address == 12'h5cc && byteenable[2:0] == 3'b111 |=>
      stream_cfg.clock_ratio_numerator == $past(writedata[23:0]))
      else $error("numerator not loaded");
   chk_pix_width: assert property (write && waitrequest &&
      address == 12'h5d8 && byteenable[0] |=>
      stream_cfg.pixel_port_width == $past(writedata[2:0]))
      else $error("pixel width not loaded");
   chk_cfg_hold: assert property (!write |=> $stable(stream_cfg))
      else $error("settings changed without a write");
   chk_line_wait: assert property (line_data_enable == (seen && rem == 8'h00))
      else $error("line enable out of step with wait count");
endmodule

bind mst_stream_video_attribute_regs stream_attr_asserts u_chk (
   .core_clk(core_clk), .rst(rst), .address(address), .read(read),
   .write(write), .writedata(writedata), .byteenable(byteenable),
   .waitrequest(waitrequest), .line_start(line_start),
   .line_data_enable(line_data_enable), .stream_cfg(stream_cfg));

// ==== stream_attr_pkg.sv ====
package stream_attr_pkg;

   localparam int          ADDR_W = 12;
   localparam int          DATA_W = 32;

   // Register byte offsets
   localparam logic [11:0] OFS_S3_TU_MIN_BYTES       = 12'h594;
   localparam logic [11:0] OFS_S3_TU_FRACTION_BYTES  = 12'h598;
   localparam logic [11:0] OFS_S3_LINE_START_WAIT    = 12'h59c;
   localparam logic [11:0] OFS_S4_HORIZONTAL_TOTAL   = 12'h5a0;
   localparam logic [11:0] OFS_S4_VERTICAL_TOTAL     = 12'h5a4;
   localparam logic [11:0] OFS_S4_SYNC_POLARITY      = 12'h5a8;
   localparam logic [11:0] OFS_S4_HSYNC_WIDTH        = 12'h5ac;
   localparam logic [11:0] OFS_S4_VSYNC_WIDTH        = 12'h5b0;
   localparam logic [11:0] OFS_S4_ACTIVE_WIDTH       = 12'h5b4;
   localparam logic [11:0] OFS_S4_ACTIVE_HEIGHT      = 12'h5b8;
   localparam logic [11:0] OFS_S4_HORIZONTAL_START   = 12'h5bc;
   localparam logic [11:0] OFS_S4_VERTICAL_START     = 12'h5c0;
   localparam logic [11:0] OFS_S4_FORMAT_ATTR_A      = 12'h5c4;
   localparam logic [11:0] OFS_S4_FORMAT_ATTR_B      = 12'h5c8;
   localparam logic [11:0] OFS_S4_CLOCK_RATIO_NUM    = 12'h5cc;
   localparam logic [11:0] OFS_S4_TRANSFER_UNIT_LEN  = 12'h5d0;
   localparam logic [11:0] OFS_S4_CLOCK_RATIO_DEN    = 12'h5d4;
   localparam logic [11:0] OFS_S4_PIXEL_PORT_WIDTH   = 12'h5d8;

   // Field widths
   localparam int          TU_MIN_W    = 8;
   localparam int          TU_FRAC_W   = 10;
   localparam int          WAIT_W      = 8;
   localparam int          TIMING_W    = 16;
   localparam int          SYNC_W      = 15;
   localparam int          ATTR_A_W    = 8;
   localparam int          ATTR_B_W    = 7;
   localparam int          RATIO_W     = 24;
   localparam int          TU_LEN_W    = 7;
   localparam int          PIX_W       = 3;

   // Field positions
   localparam int          POL_HSYNC_BIT      = 0;
   localparam int          POL_VSYNC_BIT      = 1;
   localparam int          ATTR_A_SYNC_CLK    = 0;
   localparam int          ATTR_A_FMT_LO      = 1;
   localparam int          ATTR_A_RANGE_BIT   = 3;
   localparam int          ATTR_A_YCC_BIT     = 4;
   localparam int          ATTR_A_DEPTH_LO    = 5;
   localparam int          ATTR_B_EVEN_BIT    = 0;
   localparam int          ATTR_B_STEREO_LO   = 1;

   // Reset values
   localparam logic [6:0]  TU_LEN_RESET       = 7'h40;
   localparam logic [7:0]  LINE_WAIT_RESET    = 8'h00;

   // Pixel port codes
   localparam logic [2:0]  PIX_SINGLE         = 3'h1;
   localparam logic [2:0]  PIX_DUAL           = 3'h2;
   localparam logic [2:0]  PIX_QUAD           = 3'h4;

   typedef enum logic [1:0] {
      LINE_IDLE,
      LINE_WAIT,
      LINE_SEND
   } line_state_e;

   typedef struct packed {
      logic                 read;
      logic                 write;
      logic [ADDR_W-1:0]    address;
      logic [DATA_W-1:0]    writedata;
   } bus_req_s;

   typedef struct packed {
      logic [TIMING_W-1:0]  horizontal_total;
      logic [TIMING_W-1:0]  vertical_total;
      logic                 vsync_polarity;
      logic                 hsync_polarity;
      logic [SYNC_W-1:0]    hsync_width;
      logic [SYNC_W-1:0]    vsync_width;
      logic [TIMING_W-1:0]  active_width;
      logic [TIMING_W-1:0]  active_height;
      logic [TIMING_W-1:0]  horizontal_start;
      logic [TIMING_W-1:0]  vertical_start;
      logic                 sync_clock;
      logic [1:0]           component_format;
      logic                 dynamic_range;
      logic                 ycbcr_colorimetry;
      logic [2:0]           bit_depth;
      logic                 interlace_even;
      logic [1:0]           stereo_attr;
      logic [RATIO_W-1:0]   clock_ratio_numerator;
      logic [RATIO_W-1:0]   clock_ratio_denominator;
      logic [TU_LEN_W-1:0]  transfer_unit_length;
      logic [PIX_W-1:0]     pixel_port_width;
      logic [TU_MIN_W-1:0]  s3_tu_min_bytes;
      logic [TU_FRAC_W-1:0] s3_tu_fraction_bytes;
   } stream_cfg_s;

endpackage

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
   logic                         core_clk;
   logic                         rst;
   logic [11:0]                  address;
   logic                         read;
   logic                         write;
   logic [31:0]                  writedata;
   logic [3:0]                   byteenable;
   logic [31:0]                  readdata;
   logic                         waitrequest;
   logic [1:0]                   response;
   logic                         line_start;
   logic                         line_data_enable;
   stream_attr_pkg::stream_cfg_s stream_cfg;
   int                           num_errors;
   int                           total_checks;
   int                           cycles;
   logic [31:0]                  rd;
   logic [1:0]                   rs;
   logic [31:0]                  mask [18];
   logic [7:0]                   mins [3];

   mst_stream_video_attribute_regs dut (
      .core_clk(core_clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .response(response),
      .line_start(line_start), .line_data_enable(line_data_enable),
      .stream_cfg(stream_cfg));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Request held until waitrequest is seen low at a rising edge
   task automatic access(input logic wr, input logic [11:0] a,
                         input logic [31:0] d, input logic [3:0] be);
      read       <= ~wr;
      write      <= wr;
      address    <= a;
      writedata  <= d;
      byteenable <= be;
      @(posedge core_clk);
      while (waitrequest !== 1'b0)
         @(posedge core_clk);
      rd = readdata;
      rs = response;
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      access(1'b1, a, d, 4'hf);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      access(1'b0, a, 32'h0, 4'hf);
      check(rd, exp);
   endtask

   task automatic idle();
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge core_clk);
   endtask

   // Pulse a line start and count cycles until data may flow
   task automatic line_run(input int w);
      int n;
      n = 0;
      line_start <= 1'b1;
      @(posedge core_clk);
      line_start <= 1'b0;
      @(negedge core_clk);
      while (line_data_enable !== 1'b1 && n < 300) begin
         n++;
         @(negedge core_clk);
      end
      check(32'(n), 32'(w));
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         $display("BAD %0t run did not finish", $time);
         stop_test();
      end
   end

   initial begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 12'h000;
      writedata = 32'h0;
      byteenable = 4'h0;
      line_start = 1'b0;
      mask = '{32'hff, 32'h3ff, 32'hff, 32'hffff, 32'hffff, 32'h3, 32'h7fff,
               32'h7fff, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hff,
               32'h7, 32'hffffff, 32'h7e, 32'hffffff, 32'h7};
      mins = '{8'h3c, 8'h04, 8'h28};
      repeat (6) @(posedge core_clk);
      check(32'(stream_cfg.transfer_unit_length), 32'h40);
      rst <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 18; i++)
         rd_chk(12'h594 + 12'(4 * i), (i == 15) ? 32'h40 : 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 18; i++) begin
         wr_reg(12'h594 + 12'(4 * i), 32'hffffffff);
         rd_chk(12'h594 + 12'(4 * i), mask[i]);
         wr_reg(12'h594 + 12'(4 * i), 32'h5a5a5a5a);
         rd_chk(12'h594 + 12'(4 * i), 32'h5a5a5a5a & mask[i]);
      end
      $display("test readback done");
      access(1'b1, 12'h5a0, 32'h12, 4'h1);
      check(32'(stream_cfg.horizontal_total), 32'h5a12);
      wr_reg(12'h5a8, 32'h2);
      check({stream_cfg.vsync_polarity, stream_cfg.hsync_polarity}, 2'b10);
      wr_reg(12'h5c4, 32'hb5);
      check({stream_cfg.sync_clock, stream_cfg.component_format, stream_cfg.dynamic_range, stream_cfg.ycbcr_colorimetry, stream_cfg.bit_depth}, 8'b1_10_0_1_101);
      wr_reg(12'h5c8, 32'h7d);
      check({stream_cfg.interlace_even, stream_cfg.stereo_attr}, 3'b110);
      rd_chk(12'h5c8, 32'h5);
      wr_reg(12'h5cc, 32'h12abcdef);
      wr_reg(12'h5d4, 32'h00876543);
      check(32'(stream_cfg.clock_ratio_numerator), 32'habcdef);
      check(32'(stream_cfg.clock_ratio_denominator), 32'h876543);
      idle();
      repeat (20) @(posedge core_clk);
      rd_chk(12'h5cc, 32'habcdef);
      rd_chk(12'h5d4, 32'h876543);
      wr_reg(12'h594, 32'h3c);
      wr_reg(12'h598, 32'h3e7);
      check(32'(stream_cfg.s3_tu_min_bytes), 32'h3c);
      check(32'(stream_cfg.s3_tu_fraction_bytes), 32'h3e7);
      $display("test field layout done");
      wr_reg(12'h5d0, 32'h21);
      rd_chk(12'h5d0, 32'h20);
      wr_reg(12'h5d0, 32'h41);
      rd_chk(12'h5d0, 32'h40);
      foreach (mins[i]) begin
         wr_reg(12'h5d8, 32'(1 << i));
         check(32'(stream_cfg.pixel_port_width), 32'(1 << i));
      end
      access(1'b0, 12'h000, 32'h0, 4'hf);
      check(rd, 32'h0);
      check(32'(rs), 32'h2);
      access(1'b1, 12'h7fc, 32'h1, 4'hf);
      check(32'(rs), 32'h2);
      rd_chk(12'h5d8, 32'h4);
      check(32'(rs), 32'h0);
      $display("test size, width and errors done");
      foreach (mins[i]) begin
         wr_reg(12'h594, 32'(mins[i]));
         wr_reg(12'h59c, (mins[i] <= 8'h04) ? 32'd64 : 32'(8'h40 - mins[i]));
         idle();
         line_run((mins[i] <= 8'h04) ? 64 : 64 - int'(mins[i]));
      end
      wr_reg(12'h59c, 32'h0);
      idle();
      line_run(0);
      $display("test line wait done");
      stop_test();
   end
endmodule
